// ===== core/nco_accum_increment_regs.sv
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module nco_accum_increment_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire nco_regs_pkg::wb_req_s wb_req_i,
   output nco_regs_pkg::wb_rsp_s wb_rsp_o,
   input wire logic osc_input_clock_i,
   output logic accum_wrap_o,
   output logic irq_o
);
   import nco_regs_pkg::*;

   // ==========================================================
   // helper functions
   function automatic logic idx_hit(input logic [ADR_W-1:0] at, input logic [ADR_W-1:0] want);
      idx_hit = (at == want);
   endfunction

   function automatic logic [7:0] nibble_byte(input logic [3:0] nib);
      nibble_byte = {4'h0, nib};
   endfunction

   // ==========================================================
   // input clock synchroniser and edge detect
   logic clk_meta_reg;
   logic clk_sync_reg;
   logic clk_prev_reg;

   // first stage, read only by the second
   always_ff @(posedge clk_i) begin
      clk_meta_reg <= osc_input_clock_i;
   end

   // second stage, unreset so no false edge follows reset
   always_ff @(posedge clk_i) begin
      clk_sync_reg <= clk_meta_reg;
   end

   // previous level for edge detect
   always_ff @(posedge clk_i) begin
      clk_prev_reg <= clk_sync_reg;
   end

   wire in_rise = clk_sync_reg & ~clk_prev_reg;
   wire in_fall = ~clk_sync_reg & clk_prev_reg;

   // ==========================================================
   // bus decode
   // unmapped reads return zero, unmapped writes are dropped
   wire bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
   wire lane0 = wb_req_i.sel[0];
   wire [ADR_W-1:0] idx = wb_req_i.adr[ADR_W+1:2];
   wire upper_clear = (wb_req_i.adr[31:ADR_W+2] == '0);
   wire mapped = upper_clear && (idx <= IDX_IRQ_MASK);
   wire wr = bus_req & wb_req_i.we & lane0 & mapped;
   wire rd = bus_req & ~wb_req_i.we;
   wire [7:0] wbyte = wb_req_i.dat[7:0];

   // ==========================================================
   // per-register strobes
   wire acc_low_wr = wr & idx_hit(idx, IDX_ACC_LOW);
   wire acc_high_wr = wr & idx_hit(idx, IDX_ACC_HIGH);
   wire acc_upper_wr = wr & idx_hit(idx, IDX_ACC_UPPER);
   wire step_low_wr = wr & idx_hit(idx, IDX_STEP_LOW);
   wire step_high_wr = wr & idx_hit(idx, IDX_STEP_HIGH);
   wire step_upper_wr = wr & idx_hit(idx, IDX_STEP_UPPER);
   wire control_wr = wr & idx_hit(idx, IDX_CONTROL);
   wire mask_wr = wr & idx_hit(idx, IDX_IRQ_MASK);
   wire status_rd = rd & mapped & idx_hit(idx, IDX_IRQ_STATUS);

   // ==========================================================
   // registers
   logic [ACC_W-1:0] accum_reg;
   logic [7:0] step_low_reg;
   logic [7:0] step_high_reg;
   logic [3:0] step_upper_reg;
   logic [ACC_W-1:0] step_shadow_reg;
   logic commit_pend_reg;
   logic osc_on_reg;
   logic irq_status_reg;
   logic irq_mask_reg;
   logic ack_reg;
   logic [7:0] rdata_reg;
   logic wrap_reg;

   // ==========================================================
   // next values
   logic [ACC_W-1:0] accum_next;
   logic [7:0] step_low_next;
   logic [7:0] step_high_next;
   logic [3:0] step_upper_next;
   logic [ACC_W-1:0] step_shadow_next;
   logic commit_pend_next;
   logic osc_on_next;
   logic irq_status_next;
   logic irq_mask_next;
   logic ack_next;
   logic [7:0] rdata_next;
   logic wrap_next;

   // ==========================================================
   // adder and overflow
   // carry out of the top bit is the wrap
   wire [ACC_W-1:0] step_value = {step_upper_reg, step_high_reg, step_low_reg};
   wire [ACC_W:0] sum = {1'b0, accum_reg} + {1'b0, step_shadow_reg};
   wire advance = osc_on_reg & in_rise;
   wire wrap = advance & sum[ACC_W];

   // ==========================================================
   // accumulator, a running add beats a software write
   always_comb begin
      accum_next = accum_reg;
      if (advance) begin
         accum_next = sum[ACC_W-1:0];
      end else if (acc_low_wr) begin
         accum_next[7:0] = wbyte;
      end else if (acc_high_wr) begin
         accum_next[15:8] = wbyte;
      end else if (acc_upper_wr) begin
         accum_next[19:16] = wbyte[3:0] & UPPER_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accum_reg <= ACCUM_RESET;
      end else begin
         accum_reg <= accum_next;
      end
   end

   // ==========================================================
   // software-visible increment bytes
   assign step_low_next = step_low_wr ? wbyte : step_low_reg;
   assign step_high_next = step_high_wr ? wbyte : step_high_reg;
   assign step_upper_next = step_upper_wr ? wbyte[3:0] : step_upper_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_low_reg <= STEP_LOW_RESET;
      end else begin
         step_low_reg <= step_low_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_high_reg <= BYTE_RESET;
      end else begin
         step_high_reg <= step_high_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_upper_reg <= BYTE_RESET[3:0];
      end else begin
         step_upper_reg <= step_upper_next;
      end
   end

   // ==========================================================
   // shadow, while running a commit waits for a falling input edge; while stopped it follows the increment at once
   always_comb begin
      step_shadow_next = step_shadow_reg;
      commit_pend_next = commit_pend_reg;
      if (!osc_on_reg) begin
         step_shadow_next = step_value;
         commit_pend_next = 1'b0;
      end else if (commit_pend_reg && in_fall) begin
         step_shadow_next = step_value;
         commit_pend_next = step_low_wr;
      end else if (step_low_wr) begin
         commit_pend_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_shadow_reg <= SHADOW_RESET;
      end else begin
         step_shadow_reg <= step_shadow_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         commit_pend_reg <= FLAG_RESET;
      end else begin
         commit_pend_reg <= commit_pend_next;
      end
   end

   // ==========================================================
   // control, interrupt status and mask
   assign osc_on_next = control_wr ? wbyte[CTRL_ON_BIT] : osc_on_reg;
   assign irq_mask_next = mask_wr ? wbyte[IRQ_WRAP_BIT] : irq_mask_reg;
   // a wrap in the clearing cycle keeps the flag set
   assign irq_status_next = wrap | (irq_status_reg & ~status_rd);
   assign wrap_next = wrap;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_on_reg <= FLAG_RESET;
      end else begin
         osc_on_reg <= osc_on_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= FLAG_RESET;
      end else begin
         irq_mask_reg <= irq_mask_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= FLAG_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wrap_reg <= FLAG_RESET;
      end else begin
         wrap_reg <= wrap_next;
      end
   end

   // ==========================================================
   // read values, live with no snapshot
   wire [7:0] acc_low_val = accum_reg[7:0];
   wire [7:0] acc_high_val = accum_reg[15:8];
   wire [7:0] acc_upper_val = nibble_byte(accum_reg[19:16]);
   wire [7:0] step_low_val = step_low_reg;
   wire [7:0] step_high_val = step_high_reg;
   wire [7:0] step_upper_val = nibble_byte(step_upper_reg);
   wire [7:0] control_val = {osc_on_reg, 7'h00};
   wire [7:0] status_val = {7'h00, irq_status_reg};
   wire [7:0] mask_val = {7'h00, irq_mask_reg};

   // ==========================================================
   // read mux
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      if (!mapped) begin
         rmux = 8'h00;
      end else if (idx_hit(idx, IDX_ACC_LOW)) begin
         rmux = acc_low_val;
      end else if (idx_hit(idx, IDX_ACC_HIGH)) begin
         rmux = acc_high_val;
      end else if (idx_hit(idx, IDX_ACC_UPPER)) begin
         rmux = acc_upper_val;
      end else if (idx_hit(idx, IDX_STEP_LOW)) begin
         rmux = step_low_val;
      end else if (idx_hit(idx, IDX_STEP_HIGH)) begin
         rmux = step_high_val;
      end else if (idx_hit(idx, IDX_STEP_UPPER)) begin
         rmux = step_upper_val;
      end else if (idx_hit(idx, IDX_CONTROL)) begin
         rmux = control_val;
      end else if (idx_hit(idx, IDX_IRQ_STATUS)) begin
         rmux = status_val;
      end else begin
         rmux = mask_val;
      end
   end

   assign rdata_next = rd ? rmux : rdata_reg;
   assign ack_next = bus_req;

   // ==========================================================
   // bus answer, one cycle after the request is taken
   // ack drops the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= FLAG_RESET;
      end else begin
         ack_reg <= ack_next;
      end
   end

   // read data held until the next read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= BYTE_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // outputs
   assign wb_rsp_o.ack = ack_reg;
   assign wb_rsp_o.dat = {24'h00_0000, rdata_reg};
   assign accum_wrap_o = wrap_reg;
   assign irq_o = irq_status_reg & irq_mask_reg;
endmodule

// ===== core/nco_regs_pkg.sv
package nco_regs_pkg;
   localparam int ACC_W = 20;
   localparam int ADR_W = 4;
   // register word offsets, byte address = 4 * index
   localparam logic [ADR_W-1:0] IDX_ACC_LOW = 4'h0;
   localparam logic [ADR_W-1:0] IDX_ACC_HIGH = 4'h1;
   localparam logic [ADR_W-1:0] IDX_ACC_UPPER = 4'h2;
   localparam logic [ADR_W-1:0] IDX_STEP_LOW = 4'h3;
   localparam logic [ADR_W-1:0] IDX_STEP_HIGH = 4'h4;
   localparam logic [ADR_W-1:0] IDX_STEP_UPPER = 4'h5;
   localparam logic [ADR_W-1:0] IDX_CONTROL = 4'h6;
   localparam logic [ADR_W-1:0] IDX_IRQ_STATUS = 4'h7;
   localparam logic [ADR_W-1:0] IDX_IRQ_MASK = 4'h8;
   localparam int CTRL_ON_BIT = 7;
   localparam int IRQ_WRAP_BIT = 0;
   localparam logic [7:0] STEP_LOW_RESET = 8'h01;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] UPPER_MASK = 4'hf;
   localparam logic [ACC_W-1:0] ACCUM_RESET = 20'h0_0000;
   localparam logic [ACC_W-1:0] SHADOW_RESET = 20'h0_0001;
   localparam logic FLAG_RESET = 1'b0;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [31:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_s;
endpackage

// ===== tb/nco_accum_increment_regs_assertions.sv
`timescale 1ns/1ps
// =====
// port checks
module nco_regs_checker (
   input logic clk_i,
   input logic rst_i,
   input nco_regs_pkg::wb_req_s wb_req_i,
   input nco_regs_pkg::wb_rsp_s wb_rsp_o,
   input logic osc_input_clock_i,
   input logic accum_wrap_o,
   input logic irq_o
);
   import nco_regs_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence taken_s; wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack; endsequence
   sequence quiet_s; !osc_input_clock_i [*8]; endsequence
   bus_answer_a: assert property (taken_s |=> wb_rsp_o.ack) else $error("no ack");
   ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack held");
   read_width_a: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h00_0000) else $error("wide");
   upper_zero_a: assert property (wb_rsp_o.ack && !wb_req_i.we && (wb_req_i.adr == 32'h0000_0008 ||
      wb_req_i.adr == 32'h0000_0014) |-> wb_rsp_o.dat[7:4] == 4'h0) else $error("nibble set");
   reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !wb_rsp_o.ack && !irq_o && !accum_wrap_o)
      else $error("reset");
   wrap_pulse_a: assert property (accum_wrap_o |=> !accum_wrap_o) else $error("wrap held");
   wrap_cause_a: assert property (quiet_s |=> !accum_wrap_o) else $error("wrap idle");
   irq_sticky_a: assert property ($fell(irq_o) |-> $past(wb_req_i.cyc)) else $error("irq lost");
endmodule
bind nco_accum_increment_regs nco_regs_checker nco_regs_checker_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .osc_input_clock_i(osc_input_clock_i),
   .accum_wrap_o(accum_wrap_o), .irq_o(irq_o));

// ===== tb/nco_accum_increment_regs_tb_top.sv
`timescale 1ns/1ps
// =====
// bench
module nco_accum_increment_regs_tb_top;
   import nco_regs_pkg::*;
   logic clk_i;
   logic rst_i = 1'b1;
   logic osc_input_clock_i = 1'b0;
   wb_req_s wb_req_i = '0;
   wb_rsp_s wb_rsp_o;
   logic accum_wrap_o;
   logic irq_o;
   int mismatches = 0;
   int cmp_count = 0;
   logic [7:0] rd;
   int wrap_count = 0;
   always @(posedge clk_i) begin
      if (accum_wrap_o === 1'b1) wrap_count <= wrap_count + 1;
   end
   nco_accum_increment_regs nco_accum_increment_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
      .wb_rsp_o(wb_rsp_o), .osc_input_clock_i(osc_input_clock_i), .accum_wrap_o(accum_wrap_o), .irq_o(irq_o));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic bus(input logic we, input logic [3:0] idx, input logic [7:0] wd);
      @(posedge clk_i);
      wb_req_i <= '{1'b1, 1'b1, we, {26'h0, idx, 2'h0}, 4'h1, {24'h00_0000, wd}};
      do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
      rd = wb_rsp_o.dat[7:0];
      wb_req_i <= '0;
   endtask
   task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk($sformatf("reg %0d", idx), exp, rd);
   endtask
   task automatic pulse();
      osc_input_clock_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      osc_input_clock_i <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #20000;
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 10; i++) rdc(i[3:0], (i == 3) ? STEP_LOW_RESET : BYTE_RESET);
      bus(1'b1, IDX_STEP_UPPER, 8'hf8);
      bus(1'b1, IDX_STEP_LOW, 8'h00);
      rdc(IDX_STEP_UPPER, 8'h08);
      rdc(IDX_STEP_LOW, 8'h00);
      bus(1'b1, IDX_IRQ_MASK, 8'h01);
      bus(1'b1, IDX_CONTROL, 8'h80);
      pulse();
      rdc(IDX_ACC_UPPER, 8'h08);
      rdc(IDX_ACC_LOW, 8'h00);
      bus(1'b1, IDX_STEP_UPPER, 8'h00);
      pulse();
      rdc(IDX_ACC_UPPER, 8'h00);
      chk("irq", 8'h01, {7'h0, irq_o});
      rdc(IDX_IRQ_STATUS, 8'h01);
      @(posedge clk_i);
      chk("irq", 8'h00, {7'h0, irq_o});
      rdc(IDX_IRQ_STATUS, 8'h00);
      bus(1'b1, IDX_STEP_LOW, 8'h10);
      pulse();
      pulse();
      rdc(IDX_ACC_LOW, 8'h10);
      rdc(IDX_ACC_UPPER, 8'h08);
      chk("wrap count", 8'h01, wrap_count[7:0]);
      rdc(IDX_CONTROL, 8'h80);
      bus(1'b1, IDX_CONTROL, 8'h00);
      bus(1'b1, IDX_ACC_LOW, 8'h5a);
      bus(1'b1, IDX_ACC_HIGH, 8'ha5);
      bus(1'b1, IDX_ACC_UPPER, 8'hf3);
      rdc(IDX_ACC_LOW, 8'h5a);
      rdc(IDX_ACC_HIGH, 8'ha5);
      rdc(IDX_ACC_UPPER, 8'h03);
      pulse();
      rdc(IDX_ACC_LOW, 8'h5a);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(IDX_ACC_HIGH, 8'h00);
      rdc(IDX_STEP_LOW, STEP_LOW_RESET);
      rdc(IDX_CONTROL, 8'h00);
      wrap_up();
   end
endmodule
